// ---- rtl/adc_sequencer_registers.sv ----
// Converter sequencer: APB registers, trigger, compare and result interlock
//
// Added by the designer: the register offsets and the APB register port.
`include "adc_seq_defines.svh"
`default_nettype none
module adc_sequencer_registers
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        hardwareTriggerIn,
  input  wire logic [9:0]  analogResult,
  output var  logic        completionIrq,
  output var  logic        converterEnable,
  output var  logic        sampleActive,
  output var  logic [4:0]  channelSelect,
  output var  logic        lowPowerConfig
);
  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Side effects act once per transfer, on the first access-phase edge,
  // so a completion between the two edges is never cleared unseen
  wire access  = psel && penable && !pready;
  wire wrStb   = access && pwrite;
  wire rdStb   = access && !pwrite;
  wire hitCtrl = (paddr == `OFS_CONV_CTRL);
  wire hitTrig = (paddr == `OFS_CMP_TRIG);
  wire hitRh   = (paddr == `OFS_RESULT_HIGH);
  wire hitRl   = (paddr == `OFS_RESULT_LOW);
  wire hitCvh  = (paddr == `OFS_CMP_HIGH);
  wire hitCvl  = (paddr == `OFS_CMP_LOW);
  wire hitCfg  = (paddr == `OFS_CONFIG);
  wire hitAin  = (paddr == `OFS_ANALOG_IN);
  wire mapped  = hitCtrl || hitTrig || hitRh || hitRl || hitCvh
              || hitCvl || hitCfg || hitAin;
  wire wrCtrl  = wrStb && hitCtrl;
  wire wrTrig  = wrStb && hitTrig;
  wire rdRh    = rdStb && hitRh;
  wire rdRl    = rdStb && hitRl;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic       complete_r;
  logic       irqEn_r;
  logic       contEn_r;
  logic [4:0] chan_r;
  logic       trigSel_r;
  logic       cmpEn_r;
  logic       cmpGe_r;
  logic [1:0] cvHigh_r;
  logic [7:0] cvLow_r;
  logic [7:0] cfg_r;
  logic [1:0] resHigh_r;
  logic [7:0] resLow_r;
  logic       locked_r;
  logic       trigPrev_r;
  adc_seq_pkg::seq_state_t state_r;
  adc_seq_pkg::seq_state_t state_nxt;
  logic [4:0] phaseCnt_r;
  logic [4:0] phaseCnt_nxt;

  wire [1:0] modeSel  = cfg_r[3:2];
  wire       tenBit   = (modeSel == `MODE_10BIT);
  wire [1:0] divSel   = cfg_r[6:5];
  wire [1:0] clkSel   = cfg_r[1:0];
  wire       longSamp = cfg_r[`BIT_LONG_SAMPLE];
  wire       chanOff  = (chan_r == `CHAN_OFF);
  wire       wrOff    = (pwdata[4:0] == `CHAN_OFF);

  // ----------------------------------------------------------------
  // Start sources
  // ----------------------------------------------------------------
  wire hwEdge   = hardwareTriggerIn && !trigPrev_r;
  // Software start follows the control write; hardware needs the edge
  wire swStart  = wrCtrl && !wrOff && !trigSel_r;
  wire hwStart  = trigSel_r && hwEdge && !chanOff
               && !wrCtrl;
  wire running  = (state_r != adc_seq_pkg::ST_IDLE);
  wire tick;
  wire endConv;

  adc_clk_div u_div
  (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (running),
    .srcSel  (clkSel),
    .divSel  (divSel),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // Rounding and compare
  // ----------------------------------------------------------------
  wire [10:0] rounded10 = {1'b0, analogResult};
  wire [8:0]  round8Sum = {1'b0, analogResult[9:2]}
                        + {8'h00, analogResult[1]};
  // Rounding saturates so full scale never wraps to zero
  wire [7:0]  rounded8  = round8Sum[8] ? 8'hff : round8Sum[7:0];
  wire [9:0]  result    = tenBit ? rounded10[9:0]
                                 : {2'b00, rounded8};
  wire [9:0]  cmpValue  = tenBit ? {cvHigh_r, cvLow_r}
                                 : {2'b00, cvLow_r};
  wire        isLess    = (result < cmpValue);
  wire        cmpTrue   = cmpGe_r ? !isLess : isLess;
  wire        accept    = !cmpEn_r || cmpTrue;
  // Interlock only exists in 10-bit mode
  wire        blocked   = tenBit && locked_r;
  wire        loadRes   = endConv && accept && !blocked;
  wire        setFlag   = endConv && accept;

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  assign endConv = (state_r == adc_seq_pkg::ST_CONV) && tick
                && (phaseCnt_r == 5'h0) && !wrCtrl;

  always_comb
  begin
    state_nxt    = state_r;
    phaseCnt_nxt = phaseCnt_r;
    if (wrCtrl)
    begin
      // Any control write aborts the conversion in flight
      state_nxt    = swStart ? adc_seq_pkg::ST_SAMPLE
                             : adc_seq_pkg::ST_IDLE;
      phaseCnt_nxt = longSamp ? `SAMPLE_LONG : `SAMPLE_SHORT;
    end
    else if (chanOff)
    begin
      state_nxt    = adc_seq_pkg::ST_IDLE;
      phaseCnt_nxt = 5'h0;
    end
    else
    begin
      case (state_r)
        adc_seq_pkg::ST_IDLE:
        begin
          if (hwStart)
          begin
            state_nxt    = adc_seq_pkg::ST_SAMPLE;
            phaseCnt_nxt = longSamp ? `SAMPLE_LONG : `SAMPLE_SHORT;
          end
        end
        adc_seq_pkg::ST_SAMPLE:
        begin
          if (tick)
          begin
            if (phaseCnt_r == 5'h0)
            begin
              state_nxt    = adc_seq_pkg::ST_CONV;
              phaseCnt_nxt = `CONV_BITS;
            end
            else
            begin
              phaseCnt_nxt = phaseCnt_r - 5'h1;
            end
          end
        end
        adc_seq_pkg::ST_CONV:
        begin
          if (tick)
          begin
            if (phaseCnt_r == 5'h0)
            begin
              // Single mode drops back to idle, the low-power state
              state_nxt    = contEn_r ? adc_seq_pkg::ST_SAMPLE
                                      : adc_seq_pkg::ST_IDLE;
              phaseCnt_nxt = longSamp ? `SAMPLE_LONG : `SAMPLE_SHORT;
            end
            else
            begin
              phaseCnt_nxt = phaseCnt_r - 5'h1;
            end
          end
        end
        default:
        begin
          state_nxt    = adc_seq_pkg::ST_IDLE;
          phaseCnt_nxt = 5'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r    <= adc_seq_pkg::ST_IDLE;
      phaseCnt_r <= 5'h0;
      trigPrev_r <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      phaseCnt_r <= phaseCnt_nxt;
      trigPrev_r <= hardwareTriggerIn;
    end
  end

  // ----------------------------------------------------------------
  // Control and configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqEn_r   <= 1'b0;
      contEn_r  <= 1'b0;
      chan_r    <= 5'(`RST_CONV_CTRL);
      trigSel_r <= 1'b0;
      cmpEn_r   <= 1'b0;
      cmpGe_r   <= 1'b0;
      cvHigh_r  <= 2'h0;
      cvLow_r   <= `RST_BYTE;
      cfg_r     <= `RST_BYTE;
    end
    else
    begin
      if (wrCtrl)
      begin
        irqEn_r  <= pwdata[`BIT_IRQ_EN];
        contEn_r <= pwdata[`BIT_CONTINUOUS];
        chan_r   <= pwdata[4:0];
      end
      if (wrTrig)
      begin
        // Low four bits are reserved; software keeps them zero
        trigSel_r <= pwdata[`BIT_TRIG_SEL];
        cmpEn_r   <= pwdata[`BIT_CMP_EN];
        cmpGe_r   <= pwdata[`BIT_CMP_GE];
      end
      if (wrStb && hitCvh)
        cvHigh_r <= pwdata[1:0];
      if (wrStb && hitCvl)
        cvLow_r <= pwdata[7:0];
      if (wrStb && hitCfg)
        cfg_r <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Flag, results and interlock
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      complete_r <= 1'b0;
      resHigh_r  <= 2'h0;
      resLow_r   <= `RST_BYTE;
      locked_r   <= 1'b0;
    end
    else
    begin
      // Completion wins over a low-result read in the same cycle
      if (setFlag)
        complete_r <= 1'b1;
      else if (wrCtrl || rdRl)
        complete_r <= 1'b0;
      if (loadRes)
      begin
        resHigh_r <= result[9:8];
        resLow_r  <= result[7:0];
      end
      if (rdRl || !tenBit)
        locked_r <= 1'b0;
      else if (rdRh)
        locked_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read data and outputs
  // ----------------------------------------------------------------
  wire [7:0] ctrlRd = {complete_r, irqEn_r, contEn_r, chan_r};
  wire [7:0] trigRd = {running, trigSel_r, cmpEn_r, cmpGe_r, 4'h0};
  wire [7:0] rhRd   = tenBit ? {6'h00, resHigh_r} : 8'h00;
  wire [7:0] rdByte = hitCtrl ? ctrlRd
                    : hitTrig ? trigRd
                    : hitRh   ? rhRd
                    : hitRl   ? resLow_r
                    : hitCvh  ? {6'h00, cvHigh_r}
                    : hitCvl  ? cvLow_r
                    : hitCfg  ? cfg_r
                    : {6'h00, modeSel};
  wire       irqNxt = complete_r && irqEn_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata          <= 32'h0000_0000;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      completionIrq   <= 1'b0;
      converterEnable <= 1'b0;
      sampleActive    <= 1'b0;
      channelSelect   <= `CHAN_OFF;
      lowPowerConfig  <= 1'b0;
    end
    else
    begin
      // One wait state: answer in the cycle after the access phase opens
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata  <= (rdStb && !pready && mapped) ? {24'h0, rdByte}
                                              : 32'h0000_0000;
      completionIrq   <= irqNxt;
      converterEnable <= running && !chanOff;
      sampleActive    <= (state_nxt == adc_seq_pkg::ST_SAMPLE);
      channelSelect   <= chan_r;
      lowPowerConfig  <= cfg_r[7];
    end
  end
endmodule
`default_nettype wire

// ---- common/adc_seq_defines.svh ----
// Register offsets, field positions, reset values and timing counts
//
// Functional notes
// - Control write aborts and restarts unless channel off; only aborts with hardware trigger
// - Completion flag sets on done, gated by compare
// - Flag clears on control write or low read
// - Interrupt when flag sets with enable high
// - Continuous bit picks single or repeated conversion
// - Five-bit channel select, references and reserved code
// - All-ones channel turns converter off, no conversion
// - Single mode idles in low power after completion
// - Active bit set on start, cleared on end
// - Trigger select picks software write or hardware input
// - Compare enable bit gates compare function
// - Compare less-than, or greater-equal when bit set
// - High result upper bits read zero in 8-bit
// - Results load unless compare enabled and false
// - 10-bit high read blocks loads until low read
// - No read interlock in 8-bit mode
// - 10-bit compares both bytes, 8-bit low only
// - Divide field selects 1, 2, 4 or 8
// - Mode field 00 eight-bit, 10 ten-bit
// - Clock field 00 bus, 01 bus halved
// - Long sample bit stretches sampling phase
// - Disabled in reset, bus clock selected after reset
// - Results rounded to width, 8-bit in low only
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

`define OFS_CONV_CTRL    12'h000
`define OFS_CMP_TRIG     12'h004
`define OFS_RESULT_HIGH  12'h008
`define OFS_RESULT_LOW   12'h00c
`define OFS_CMP_HIGH     12'h010
`define OFS_CMP_LOW      12'h014
`define OFS_CONFIG       12'h018
`define OFS_ANALOG_IN    12'h01c

`define BIT_COMPLETE     7
`define BIT_IRQ_EN       6
`define BIT_CONTINUOUS   5
`define BIT_ACTIVE       7
`define BIT_TRIG_SEL     6
`define BIT_CMP_EN       5
`define BIT_CMP_GE       4
`define BIT_LONG_SAMPLE  4
`define CHAN_OFF         5'h1f
`define CHAN_RESERVED    5'h1c
`define MODE_8BIT        2'h0
`define MODE_10BIT       2'h2

`define RST_CONV_CTRL    8'h1f
`define RST_BYTE         8'h00

`define SAMPLE_SHORT     5'h03
`define SAMPLE_LONG      5'h17
`define CONV_BITS        5'h0a

`endif

// ---- common/adc_seq_pkg.sv ----
// Types shared by the converter sequencer
`default_nettype none
package adc_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b10
  } seq_state_t;
endpackage
`default_nettype wire

// ---- rtl/adc_clk_div.sv ----
// Conversion clock enable generator: source select then power-of-two divide
`default_nettype none
module adc_clk_div
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       run,
  input  wire logic [1:0] srcSel,
  input  wire logic [1:0] divSel,
  output var  logic       tick
);
  logic [3:0] cnt_r;
  logic [3:0] limit;

  // Halved bus source doubles the count; divide field shifts it
  assign limit = (srcSel == 2'h1) ? (4'h2 << divSel) - 4'h1
                                  : (4'h1 << divSel) - 4'h1;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r <= 4'h0;
      tick  <= 1'b0;
    end
    else if (!run || cnt_r >= limit)
    begin
      cnt_r <= 4'h0;
      tick  <= run;
    end
    else
    begin
      cnt_r <= cnt_r + 4'h1;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- bench/adc_seq_chk.sv ----
// Port assertions for the converter sequencer
`default_nettype none
module adc_seq_chk
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        converterEnable,
  input wire logic        sampleActive,
  input wire logic [4:0]  channelSelect
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  wire logic acc   = psel && penable && !pready;
  wire logic wrCtl = acc && pwrite && paddr == 12'h0;
  property p_rst; $rose(reset_n) |-> channelSelect == 5'h1f; endproperty
  a_rst: assert property (p_rst) else $error("not off");
  property p_ans; acc |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("late ready");
  property p_pulse; pready |=> !pready && prdata == 32'h0; endproperty
  a_pulse: assert property (p_pulse) else $error("long answer");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  // Both outputs lag the channel field by the same cycle
  property p_off; channelSelect == 5'h1f |-> !converterEnable; endproperty
  a_off: assert property (p_off) else $error("runs while off");
  property p_samp; $rose(converterEnable) |-> ##[0:1] sampleActive;
  endproperty
  a_samp: assert property (p_samp) else $error("no sampling");
  property p_chan;
    wrCtl |-> ##2 channelSelect == $past(pwdata[4:0], 2);
  endproperty
  a_chan: assert property (p_chan) else $error("bad channel");
  property p_stop;
    wrCtl && pwdata[4:0] == 5'h1f |-> ##2 !converterEnable;
  endproperty
  a_stop: assert property (p_stop) else $error("no abort");
endmodule
bind adc_sequencer_registers adc_seq_chk chk_i
(
  .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .converterEnable, .sampleActive, .channelSelect
);
`default_nettype wire

// ---- bench/trig_timer_model.sv ----
// Timer model that pulses the hardware trigger on each overflow
`default_nettype none
module trig_timer_model
#(parameter int PERIOD = 300)
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic run,
  output var  logic trig
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Stopped timer holds at zero, so no stray pulse on restart
  always_ff @(posedge clk)
  begin
    cnt  <= (!reset_n || !run || cnt == PERIOD - 1) ? 0 : cnt + 1;
    trig <= reset_n && run && cnt == PERIOD - 1;
  end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the converter sequencer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset_n, psel, penable, pwrite, err, run, ten, cmpOn;
  logic        pready, pslverr, irq, convEn, lowPwr, hwTrig, ge, cond;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  analog, res, cv, held;
  logic [7:0]  cfg, cvl, cvh, expH, expL;
  logic [4:0]  chanSel;
  int          mismatches, cmp_count, seed, i;
  adc_sequencer_registers uut
  (
    .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .hardwareTriggerIn(hwTrig), .analogResult(analog),
    .completionIrq(irq), .converterEnable(convEn), .sampleActive(),
    .channelSelect(chanSel), .lowPowerConfig(lowPwr)
  );
  trig_timer_model tmr (.clk, .reset_n, .run, .trig(hwTrig));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task complete_run();
    $display("checks %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Request stays put until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (!pready);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task rdc(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h0);
    chk(rd, {24'h0, e});
  endtask
  task automatic waitflag();
    do
      apb(1'b0, 12'h0, 8'h0);
    while (!rd[7]);
  endtask
  // One software-started conversion of a fresh random input
  task automatic convert();
    analog <= 10'($random(seed));
    apb(1'b1, 12'h0, 8'h43);
    apb(1'b0, 12'h4, 8'h0);
    chk(rd[7], 1'b1);
    while (convEn)
      @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  function logic [7:0] round8(input logic [9:0] v);
    return v[9:2] == 8'hff ? 8'hff : v[9:2] + 8'(v[1]);
  endfunction
  initial
  begin
    seed = 32'hc1e0d944;
    {reset_n, psel, penable, pwrite, run, paddr, pwdata, analog} = '0;
    {expH, expL} = '0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    chk(chanSel, 5'h1f);
    rdc(12'h0, 8'h1f);
    rdc(12'h18, 8'h0);
    apb(1'b0, 12'h20, 8'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    for (i = 0; i < 12; i++)
    begin
      {ten, cmpOn, ge, cvl, cvh} = 19'($random(seed));
      cfg = {i[2], 2'($random(seed)), i[1], ten, 2'b00, i[0]};
      apb(1'b1, 12'h18, cfg);
      apb(1'b1, 12'h10, cvh);
      apb(1'b1, 12'h14, cvl);
      apb(1'b1, 12'h4, {2'b00, cmpOn, ge, 4'h0});
      rdc(12'h18, cfg);
      chk(lowPwr, cfg[7]);
      convert();
      res = ten ? analog : {2'b00, round8(analog)};
      cv = ten ? {cvh[1:0], cvl} : {2'b00, cvl};
      cond = !cmpOn || (ge ? res >= cv : res < cv);
      if (cond) {expH, expL} = {6'h0, res};
      rdc(12'h0, {cond, 7'h43});
      chk(irq, cond);
      chk(convEn, 1'b0);
      if (cond || !ten) rdc(12'h8, ten ? expH : 8'h0);
      rdc(12'hc, expL);
      rdc(12'h0, 8'h43);
    end
    apb(1'b1, 12'h4, 8'h0);
    apb(1'b1, 12'h18, 8'h08);
    rdc(12'h1c, 8'h02);
    convert();
    held = analog;
    apb(1'b0, 12'h8, 8'h0);
    convert();
    rdc(12'hc, held[7:0]);
    convert();
    rdc(12'h8, {6'h0, analog[9:8]});
    rdc(12'hc, analog[7:0]);
    apb(1'b1, 12'h18, 8'h0);
    convert();
    apb(1'b0, 12'h8, 8'h0);
    convert();
    rdc(12'hc, round8(analog));
    apb(1'b1, 12'h0, 8'h23);
    waitflag();
    apb(1'b0, 12'hc, 8'h0);
    waitflag();
    chk(rd[7:0], 8'ha3);
    chk(convEn, 1'b1);
    apb(1'b1, 12'h0, 8'h1f);
    repeat (100) @(posedge clk);
    rdc(12'h0, 8'h1f);
    apb(1'b1, 12'h4, 8'h40);
    apb(1'b1, 12'h0, 8'h03);
    repeat (20) @(posedge clk);
    chk(convEn, 1'b0);
    run <= 1'b1;
    waitflag();
    chk(rd[7:0], 8'h83);
    chk(irq, 1'b0);
    complete_run();
  end
  initial
  begin
    #400us;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
